//--- mxarb_top.v
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "mxarb_regs.vh"
module mxarb_top #(
  parameter integer SHORT_CYCLES = `MXARB_SHORT_TO_US * `MXARB_CLK_MHZ,
  parameter integer LONG_CYCLES = `MXARB_LONG_TO_MS * 1000 * `MXARB_CLK_MHZ
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg irq,
  // cable arbitration pins, active low; request and busy open drain (oe low drives low), grant out driven
  input wire busReqIn_n,
  output reg busReqOe_n,
  input wire grantIn_n,
  output reg grantOut_n,
  input wire busyIn_n,
  output reg busyOe_n,
  // cable transfer strobes
  input wire dataStrobeIn_n,
  input wire dtackIn_n,
  input wire berrIn_n,
  output reg berrOe_n,
  // local master side
  input wire localReq,
  input wire localDone,
  input wire remoteVmeReq,
  output reg vmeBerr,
  // vme arbitration side
  input wire vmeGrantIn_n,
  output reg vmeGrantOut_n,
  input wire vmeOwned,
  output reg vmeHold
);
  //////////////////////////////////////////////////////////////////////////////
  reg rstSync1_reg;
  reg rstSync2_reg;
  wire rstN;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end
  assign rstN = rstSync2_reg;
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, bit order: breq grant busy ds dtack berr vgrant remote
  wire [7:0] pinRaw;
  reg [7:0] pinS1_reg;
  reg [7:0] pinS2_reg;
  assign pinRaw = {~busReqIn_n, ~grantIn_n, ~busyIn_n, ~dataStrobeIn_n,
                   ~dtackIn_n, ~berrIn_n, ~vmeGrantIn_n, remoteVmeReq};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : gSync
      always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
          pinS1_reg[gi] <= 1'b0;
          pinS2_reg[gi] <= 1'b0;
        end else begin
          pinS1_reg[gi] <= pinRaw[gi];
          pinS2_reg[gi] <= pinS1_reg[gi];
        end
      end
    end
  endgenerate
  wire reqLine = pinS2_reg[7];
  wire grantIn = pinS2_reg[6];
  wire busyLine = pinS2_reg[5];
  wire dsLine = pinS2_reg[4];
  wire dtackLine = pinS2_reg[3];
  wire berrLine = pinS2_reg[2];
  wire vGrantIn = pinS2_reg[1];
  wire remoteReq = pinS2_reg[0];
  //////////////////////////////////////////////////////////////////////////////
  reg [4:0] ctrl_reg;
  reg [2:0] irqStat_reg;
  reg [2:0] irqMask_reg;
  wire sysCon = ctrl_reg[`MXARB_CTRL_SYSCON];
  wire longTo = ctrl_reg[`MXARB_CTRL_LONGTO];
  wire lockBit = ctrl_reg[`MXARB_CTRL_LOCK];
  wire fairEn = ctrl_reg[`MXARB_CTRL_FAIR];
  wire ilock = ctrl_reg[`MXARB_CTRL_ILOCK];
  //////////////////////////////////////////////////////////////////////////////
  // requester state machine
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_REQ = 2'd1;
  localparam [1:0] ST_OWN = 2'd2;
  localparam [1:0] ST_FAIR = 2'd3;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg ownHeld_reg;
  wire owning = (state_reg == ST_OWN);
  wire vmeReady = !ilock || vmeOwned;
  reg ctrlGrant_reg;
  wire grantHere = sysCon ? ctrlGrant_reg : grantIn;
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if ((localReq || lockBit) && !(fairEn && ownHeld_reg && reqLine))
          state_next = ST_REQ;
      end
      ST_REQ: begin
        if (grantHere && !busyLine && vmeReady)
          state_next = ST_OWN;
        else if (remoteReq && !ilock)
          state_next = ST_IDLE;
      end
      ST_OWN: begin
        if (localDone && !lockBit && !localReq && reqLine && (!ilock || vmeOwned))
          state_next = fairEn ? ST_FAIR : ST_IDLE;
      end
      ST_FAIR: begin
        if (!reqLine)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      state_reg <= ST_IDLE;
      ownHeld_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ownHeld_reg <= (state_next == ST_FAIR);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // system controller grant and timeout
  reg [31:0] toCnt_reg;
  reg toRun_reg;
  wire [31:0] toLimit = longTo ? LONG_CYCLES : SHORT_CYCLES;
  wire toExpire = toRun_reg && (toCnt_reg >= toLimit - 1);
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      ctrlGrant_reg <= 1'b0;
      toRun_reg <= 1'b0;
      toCnt_reg <= 32'h0000_0000;
    end else begin
      ctrlGrant_reg <= sysCon && reqLine && !busyLine;
      if (!sysCon || dtackLine || berrLine || toExpire) begin
        toRun_reg <= 1'b0;
        toCnt_reg <= 32'h0000_0000;
      end else if (dsLine) begin
        toRun_reg <= 1'b1;
        toCnt_reg <= toCnt_reg + 32'h0000_0001;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // pin drivers
  wire passIdle = (state_reg == ST_IDLE || state_reg == ST_FAIR) &&
                  (state_next == ST_IDLE || state_next == ST_FAIR);
  wire abortNow = (state_reg == ST_REQ) && remoteReq && !ilock;
  wire grantNow = (state_next == ST_OWN) && !owning;
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      busReqOe_n <= 1'b1;
      busyOe_n <= 1'b1;
    end else begin
      busReqOe_n <= !(state_next == ST_REQ);
      busyOe_n <= !(state_next == ST_OWN);
    end
  end
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      grantOut_n <= 1'b1;
    end else begin
      grantOut_n <= !(grantHere && passIdle && !(ilock && !vmeOwned));
    end
  end
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      berrOe_n <= 1'b1;
    end else begin
      berrOe_n <= !toExpire;
    end
  end
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      vmeBerr <= 1'b0;
    end else begin
      vmeBerr <= abortNow;
    end
  end
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      vmeGrantOut_n <= 1'b1;
    end else begin
      vmeGrantOut_n <= !(vGrantIn && (!ilock || owning));
    end
  end
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      vmeHold <= 1'b0;
    end else begin
      vmeHold <= ilock && (owning || state_reg == ST_REQ);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  wire [2:0] evNow = {grantNow, abortNow, toExpire};
  wire wrTake = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire wrFire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  wire wrOk = wrFire && s_axi_wstrb[0];
  wire addrOk = (s_axi_awaddr <= `MXARB_MASK_OFS) && (s_axi_awaddr[1:0] == 2'b00);
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= wrTake;
      s_axi_wready <= wrTake;
    end
  end
  // response only after both handshakes
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end else if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addrOk ? 2'b00 : 2'b10;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // control, mask and event registers
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_reg <= 5'h00;
      irqMask_reg <= 3'h0;
    end else begin
      if (wrOk && s_axi_awaddr == `MXARB_CTRL_OFS)
        ctrl_reg <= s_axi_wdata[4:0];
      if (wrOk && s_axi_awaddr == `MXARB_MASK_OFS)
        irqMask_reg <= s_axi_wdata[2:0];
    end
  end
  // set wins over write-one clear
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      irqStat_reg <= 3'h0;
    end else begin
      if (wrOk && s_axi_awaddr == `MXARB_IRQ_OFS)
        irqStat_reg <= (irqStat_reg & ~s_axi_wdata[2:0]) | evNow;
      else
        irqStat_reg <= irqStat_reg | evNow;
    end
  end
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_reg & irqMask_reg);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  wire rdTake = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire rdFire = s_axi_arready && s_axi_arvalid;
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= rdTake;
    end
  end
  // data only after the address handshake
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `MXARB_CTRL_OFS: s_axi_rdata <= {27'h0, ctrl_reg};
          `MXARB_STAT_OFS: s_axi_rdata <= {24'h0, reqLine, busyLine, grantIn, toRun_reg, ilock, 1'b0, state_reg};
          `MXARB_IRQ_OFS: s_axi_rdata <= {29'h0, irqStat_reg};
          `MXARB_MASK_OFS: s_axi_rdata <= {29'h0, irqMask_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
    end
  end
endmodule // mxarb_top

//--- mxarb_regs.vh
`ifndef MXARB_REGS_VH
`define MXARB_REGS_VH
// register byte offsets
`define MXARB_CTRL_OFS 8'h00
`define MXARB_STAT_OFS 8'h04
`define MXARB_IRQ_OFS 8'h08
`define MXARB_MASK_OFS 8'h0c
// control fields
`define MXARB_CTRL_SYSCON 0
`define MXARB_CTRL_LONGTO 1
`define MXARB_CTRL_LOCK 2
`define MXARB_CTRL_FAIR 3
`define MXARB_CTRL_ILOCK 4
`define MXARB_CTRL_RST 32'h0000_0000
// interrupt event bits
`define MXARB_EV_TIMEOUT 0
`define MXARB_EV_DEADLOCK 1
`define MXARB_EV_GRANT 2
// timing in microseconds (short) and milliseconds (long)
`define MXARB_SHORT_TO_US 200
`define MXARB_LONG_TO_MS 200
`define MXARB_CLK_MHZ 20
`endif

//--- mxarb_top_asserts.sv
`timescale 1ns/1ps
module mxarb_top_asserts #(parameter integer SHORT_CYCLES = 20) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // cable pins
  input wire busReqIn_n,
  input wire grantIn_n,
  input wire dataStrobeIn_n,
  input wire dtackIn_n,
  input wire berrIn_n,
  input wire busReqOe_n,
  input wire grantOut_n,
  input wire busyOe_n,
  input wire berrOe_n,
  // local side
  input wire localReq,
  input wire vmeBerr
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  reg [7:0] reqAge_reg;
  reg [15:0] dsAge_reg;
  ////////////////////////////////
  // age of request line and open strobe
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reqAge_reg <= 8'hff;
      dsAge_reg <= 16'h0000;
    end else begin
      reqAge_reg <= !busReqIn_n ? 8'h00 : reqAge_reg + {7'h00, reqAge_reg != 8'hff};
      dsAge_reg <= (dataStrobeIn_n || !dtackIn_n || !berrIn_n) ? 16'h0000 : dsAge_reg + 16'h0001;
    end
  end
  ////////////////////////////////
  a_tmo_early: assert property ($fell(berrOe_n) |-> int'(dsAge_reg) >= SHORT_CYCLES)
    else $error("early bus error");
  a_grant_fwd: assert property ((!grantIn_n && busReqOe_n && busyOe_n && !localReq)[*5] |-> !grantOut_n)
    else $error("grant not passed");
  a_owner_blocks: assert property ((!busyOe_n)[*6] |-> grantOut_n)
    else $error("grant passed by owner");
  a_req_drop: assert property ($fell(busyOe_n) |-> ##[0:2] busReqOe_n)
    else $error("request kept");
  a_req_off_owned: assert property ((!busyOe_n)[*3] |-> busReqOe_n)
    else $error("request while owner");
  a_busy_release: assert property ($rose(busyOe_n) |-> reqAge_reg < 8'h08)
    else $error("busy dropped unasked");
  a_grant_cause: assert property ($fell(grantOut_n) |-> reqAge_reg < 8'h08 || !grantIn_n)
    else $error("grant without request");
  a_abort_cause: assert property ($rose(vmeBerr) |-> localReq && busyOe_n)
    else $error("abort without conflict");
  c_tmo: cover property ($fell(berrOe_n));
  c_own: cover property ($fell(busyOe_n));
  c_abort: cover property ($rose(vmeBerr));
endmodule // mxarb_top_asserts

//--- mxarb_cable_peer.sv
`timescale 1ns/1ps
module mxarb_cable_peer (
  // clock and commands
  input wire sys_clk,
  input wire wantBus,
  input wire strobeOn,
  input wire ackOn,
  // dut pin drives
  input wire grantOut_n,
  input wire busReqOe_n,
  input wire busyOe_n,
  input wire berrOe_n,
  // wired lines, pulled up
  output wire busReqIn_n,
  output wire busyIn_n,
  output wire dataStrobeIn_n,
  output wire dtackIn_n,
  output wire berrIn_n,
  output reg owns
);
  reg req_reg = 1'b0;
  reg ack_reg = 1'b0;
  initial owns = 1'b0;
  ////////////////////////////////
  // request, take, release
  always @(posedge sys_clk) begin
    req_reg <= wantBus && !owns && !(req_reg && !grantOut_n);
    owns <= wantBus && (owns || (req_reg && !grantOut_n));
    ack_reg <= owns && strobeOn && ackOn;
  end
  assign dataStrobeIn_n = !(owns && strobeOn);
  assign dtackIn_n = !ack_reg;
  assign busReqIn_n = busReqOe_n && !req_reg;
  assign busyIn_n = busyOe_n && !owns;
  assign berrIn_n = berrOe_n;
endmodule // mxarb_cable_peer

//--- mxarb_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
`define WAITC(c) begin for (k = 0; k < 400 && !(c); k++) @(posedge sys_clk); if (!(c)) end_of_test(1'b1); end
module mxarb_top_tb_top;
  localparam int SHORT = 20;
  localparam int LONG = 50;
  logic sys_clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, grantIn_n = 1'b1, localReq = 1'b0, localDone = 1'b0;
  logic remoteVmeReq = 1'b0, vmeGrantIn_n = 1'b1, vmeOwned = 1'b0, wantBus = 1'b0, strobeOn = 1'b0, ackOn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [33:0] q;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, peerOwns;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire busReqIn_n, busReqOe_n, grantOut_n, busyIn_n, busyOe_n, dataStrobeIn_n, dtackIn_n, berrIn_n;
  wire berrOe_n, vmeBerr, vmeGrantOut_n, vmeHold;
  int miscompares = 0, compares = 0, k, n;
  mxarb_top #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) DUT (.*);
  mxarb_cable_peer PEER (.*, .owns(peerOwns));
  initial forever #25 sys_clk = ~sys_clk;
  ////////////////////////////////
  task automatic end_of_test(input bit hung);
    if (hung) miscompares++;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic ax(input bit wr, input logic [7:0] a, input logic [31:0] d);
    bit done;
    int i;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    done = 1'b0;
    for (i = 0; i < 99 && !done; i++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      done = wr ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1;
    end
    if (!done) end_of_test(1'b1);
    q = wr ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  // strobe left unanswered until the bus error
  task automatic tmo(input int lim);
    repeat (3) @(posedge sys_clk);
    strobeOn <= 1'b1;
    for (n = 0; berrOe_n !== 1'b0 && n < lim + 20; n++) @(posedge sys_clk);
    strobeOn <= 1'b0;
    `CHK("timeout window", 1'b1, n >= lim && n <= lim + 8)
    repeat (3) @(posedge sys_clk);
  endtask
  ////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ax(1'b0, 8'h00, 32'h0);
    `CHK("ctrl reset", 34'h0, q)
    ax(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", {2'b10, 32'h0}, q)
    ax(1'b1, 8'h0c, 32'h1);
    `CHK("write resp", 34'h0, q)
    $display("registers done");
    grantIn_n <= 1'b0;
    `WAITC(!grantOut_n)
    localReq <= 1'b1;
    `WAITC(!busyOe_n)
    repeat (6) @(posedge sys_clk);
    `CHK("grant stopped", 1'b1, grantOut_n)
    `CHK("request off", 1'b1, busReqOe_n)
    localReq <= 1'b0;
    localDone <= 1'b1;
    repeat (10) @(posedge sys_clk);
    `CHK("busy kept", 1'b0, busyOe_n)
    wantBus <= 1'b1;
    `WAITC(peerOwns)
    grantIn_n <= 1'b1;
    wantBus <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wantBus <= 1'b1;
    repeat (10) @(posedge sys_clk);
    `CHK("no arbiter", 1'b1, grantOut_n)
    $display("requester done");
    ax(1'b1, 8'h00, 32'h1);
    `WAITC(peerOwns)
    `WAITC(grantOut_n)
    ax(1'b1, 8'h08, 32'h7);
    strobeOn <= 1'b1;
    ackOn <= 1'b1;
    repeat (SHORT + 10) @(posedge sys_clk);
    `CHK("acked no irq", 1'b0, irq)
    strobeOn <= 1'b0;
    ackOn <= 1'b0;
    tmo(SHORT);
    `CHK("timeout irq", 1'b1, irq)
    ax(1'b1, 8'h08, 32'h1);
    repeat (3) @(posedge sys_clk);
    `CHK("irq cleared", 1'b0, irq)
    ax(1'b1, 8'h00, 32'h3);
    tmo(LONG);
    $display("timeout done");
    ax(1'b1, 8'h0c, 32'h2);
    ax(1'b1, 8'h08, 32'h7);
    localReq <= 1'b1;
    localDone <= 1'b0;
    remoteVmeReq <= 1'b1;
    `WAITC(vmeBerr)
    repeat (3) @(posedge sys_clk);
    `CHK("deadlock irq", 1'b1, irq)
    remoteVmeReq <= 1'b0;
    wantBus <= 1'b0;
    `WAITC(!busyOe_n)
    ax(1'b1, 8'h00, 32'h5);
    localReq <= 1'b0;
    localDone <= 1'b1;
    wantBus <= 1'b1;
    repeat (20) @(posedge sys_clk);
    `CHK("locked", 1'b0, busyOe_n)
    ax(1'b1, 8'h00, 32'h11);
    repeat (10) @(posedge sys_clk);
    `CHK("interlock hold", 1'b0, busyOe_n)
    `CHK("vme hold", 1'b1, vmeHold)
    vmeOwned <= 1'b1;
    `WAITC(peerOwns)
    vmeGrantIn_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    `CHK("vme grant held", 1'b1, vmeGrantOut_n)
    $display("deadlock lock interlock done");
    end_of_test(1'b0);
  end
endmodule // mxarb_top_tb_top
bind mxarb_top mxarb_top_asserts #(.SHORT_CYCLES(SHORT_CYCLES)) CHKR (.*);
